//--- shared/tape_pkg.sv
// Constants, types and register map of the paper tape reader and punch controller
package tape_pkg;
  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [3:0] ADDR_IOT = 4'h0;
  localparam logic [3:0] ADDR_AC = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  localparam logic [3:0] ADDR_WORD = 4'hC;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int ST_SKIP = 0;
  localparam int ST_RDR_FLAG = 1;
  localparam int ST_PUN_FLAG = 2;
  localparam int ST_READIN = 3;
  localparam int ST_RDR_BUSY = 4;
  localparam int ST_PUN_BUSY = 5;
  // ****************************************************************
  // Transfer instruction decode
  // ****************************************************************
  localparam logic [5:0] IOT_OPCODE = 6'h38;
  localparam logic [5:0] DEV_READER = 6'h01;
  localparam logic [5:0] DEV_PUNCH = 6'h02;
  localparam logic [5:0] DEV_STATUS = 6'h03;
  localparam int P_SKIP = 0;
  localparam int P_READ = 1;
  localparam int P_SELECT = 2;
  localparam int P_CLR_AC = 3;
  localparam int P_BINARY = 5;
  // Accumulator bit n sits at vector index 17-n
  localparam int AC_RDR_FLAG = 16;
  localparam int AC_PUN_FLAG = 15;
  localparam int AC_RDR_NOTAPE = 9;
  localparam int AC_PUN_NOTAPE = 8;
  localparam int HOLE8 = 7;
  localparam int HOLE7 = 6;
  localparam logic [1:0] BIN_LAST = 2'h2;
  localparam logic [17:0] AC_RESET = 18'h0_0000;
  typedef enum logic {RD_IDLE = 1'b0, RD_WAIT = 1'b1} rd_state_t;
  typedef enum logic {PU_IDLE = 1'b0, PU_BUSY = 1'b1} pu_state_t;
  typedef struct packed {
    logic [5:0] opcode;
    logic [5:0] device;
    logic [5:0] pulse;
  } iot_t;
  typedef struct packed {
    logic [7:0] data;
    logic valid;
  } frame_t;
endpackage

//--- verilog/paper_tape_ctrl.sv
// Paper tape reader and punch controller with AXI4-Lite register access
//
// Local design decisions: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module paper_tape_ctrl (
  input wire logic aclk, // 20 MHz clock
  input wire logic aresetn, // Sync reset, active low
  input wire logic [3:0] s_awaddr, // Write address
  input wire logic s_awvalid, // Write address valid
  output logic s_awready, // Write address ready
  input wire logic [31:0] s_wdata, // Write data
  input wire logic [3:0] s_wstrb, // Write byte enables
  input wire logic s_wvalid, // Write data valid
  output logic s_wready, // Write data ready
  output logic [1:0] s_bresp, // Write response
  output logic s_bvalid, // Write response valid
  input wire logic s_bready, // Write response ready
  input wire logic [3:0] s_araddr, // Read address
  input wire logic s_arvalid, // Read address valid
  output logic s_arready, // Read address ready
  output logic [31:0] s_rdata, // Read data
  output logic [1:0] s_rresp, // Read response
  output logic s_rvalid, // Read data valid
  input wire logic s_rready, // Read data ready
  input wire logic console_reset, // Console reset pulse
  input wire logic readin_key, // Console readin key pulse
  input wire tape_pkg::frame_t rdr_frame, // Frame sensed by reader
  input wire logic rdr_no_tape, // Reader out of tape
  output logic rdr_advance, // Request one frame advance
  output logic rdr_irq, // Reader interrupt request
  output logic ri_pi_req, // Word ready for readin logic
  output logic ri_skip_req, // Last word for readin logic
  output logic [17:0] ri_word, // Word for readin logic
  input wire logic pun_no_tape, // Punch out-of-tape switch
  input wire logic pun_done, // Punch mechanism finished
  output logic pun_strobe, // Start punching one frame
  output logic [7:0] pun_buf, // Punch buffer frame
  output logic pun_irq // Punch interrupt request
);
  // ****************************************************************
  // Bus slave
  // ****************************************************************
  logic aw_held, w_held, wr_fire, rdr_flag, pun_flag, skip, ri;
  logic [3:0] awaddr_q, wstrb_q;
  logic [31:0] wdata_q, status;
  logic [17:0] ac, rd_buf;
  tape_pkg::rd_state_t rd_state;
  tape_pkg::pu_state_t pu_state;

  assign wr_fire = aw_held && w_held && !s_bvalid;

  always_comb begin
    status = 32'h0000_0000;
    status[tape_pkg::ST_SKIP] = skip;
    status[tape_pkg::ST_RDR_FLAG] = rdr_flag;
    status[tape_pkg::ST_PUN_FLAG] = pun_flag;
    status[tape_pkg::ST_READIN] = ri;
    status[tape_pkg::ST_RDR_BUSY] = rd_state == tape_pkg::RD_WAIT;
    status[tape_pkg::ST_PUN_BUSY] = pu_state == tape_pkg::PU_BUSY;
  end

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      s_awready <= 1'b0;
      s_wready <= 1'b0;
      s_bvalid <= 1'b0;
      s_bresp <= tape_pkg::RESP_OKAY;
      awaddr_q <= 4'h0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_held <= 1'b1;
        s_awready <= 1'b0;
        awaddr_q <= s_awaddr;
      end else if (!aw_held && !s_bvalid) begin
        s_awready <= 1'b1;
      end
      if (s_wvalid && s_wready) begin
        w_held <= 1'b1;
        s_wready <= 1'b0;
        wdata_q <= s_wdata;
        wstrb_q <= s_wstrb;
      end else if (!w_held && !s_bvalid) begin
        s_wready <= 1'b1;
      end
      if (wr_fire) begin
        s_bvalid <= 1'b1;
        case (awaddr_q)
          tape_pkg::ADDR_IOT, tape_pkg::ADDR_AC, tape_pkg::ADDR_STATUS,
          tape_pkg::ADDR_WORD: s_bresp <= tape_pkg::RESP_OKAY;
          default: s_bresp <= tape_pkg::RESP_SLVERR;
        endcase
      end else if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0;
        aw_held <= 1'b0;
        w_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_arready <= 1'b0;
      s_rvalid <= 1'b0;
      s_rdata <= 32'h0000_0000;
      s_rresp <= tape_pkg::RESP_OKAY;
    end else if (s_arvalid && s_arready) begin
      s_arready <= 1'b0;
      s_rvalid <= 1'b1;
      s_rresp <= tape_pkg::RESP_OKAY;
      case (s_araddr)
        tape_pkg::ADDR_IOT: s_rdata <= 32'h0000_0000;
        tape_pkg::ADDR_AC: s_rdata <= {14'h0000, ac};
        tape_pkg::ADDR_STATUS: s_rdata <= status;
        tape_pkg::ADDR_WORD: s_rdata <= {14'h0000, rd_buf};
        default: begin
          s_rdata <= 32'h0000_0000;
          s_rresp <= tape_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_rvalid && s_rready) begin
      s_rvalid <= 1'b0;
      s_arready <= 1'b1;
    end else if (!s_rvalid) begin
      s_arready <= 1'b1;
    end
  end

  // ****************************************************************
  // Instruction decode
  // ****************************************************************
  tape_pkg::iot_t io_transfer_instruction;
  logic exec, rdr_cmd, pun_cmd, sts_cmd, rdr_rd, rdr_sel, pun_clr, pun_go;
  logic rd_start, rd_complete, frame_in, ri_go, last_now, rd_binary, rd_last;
  logic [1:0] rd_cnt;
  logic [17:0] next_buf;
  logic [7:0] next_pun_buf;

  assign io_transfer_instruction = wdata_q[17:0];
  assign exec = wr_fire && awaddr_q == tape_pkg::ADDR_IOT && wstrb_q != 4'h0;
  assign rdr_cmd = exec && io_transfer_instruction.opcode == tape_pkg::IOT_OPCODE
                   && io_transfer_instruction.device == tape_pkg::DEV_READER;
  assign pun_cmd = exec && io_transfer_instruction.opcode == tape_pkg::IOT_OPCODE
                   && io_transfer_instruction.device == tape_pkg::DEV_PUNCH;
  assign sts_cmd = exec && io_transfer_instruction.opcode == tape_pkg::IOT_OPCODE
                   && io_transfer_instruction.device == tape_pkg::DEV_STATUS && io_transfer_instruction.pulse[tape_pkg::P_SELECT];
  assign rdr_rd = rdr_cmd && io_transfer_instruction.pulse[tape_pkg::P_READ];
  assign rdr_sel = rdr_cmd && io_transfer_instruction.pulse[tape_pkg::P_SELECT];
  assign pun_clr = pun_cmd && io_transfer_instruction.pulse[tape_pkg::P_READ];
  // A select with the switch open is dropped here, so no frame is ever punched
  assign pun_go = pun_cmd && io_transfer_instruction.pulse[tape_pkg::P_SELECT] && !pun_no_tape
                  && pu_state == tape_pkg::PU_IDLE;

  // ****************************************************************
  // Reader
  // ****************************************************************
  assign ri_go = readin_key && !ri && rd_state == tape_pkg::RD_IDLE;
  // Readin owns the reader between words, so program selects are dropped while it runs
  assign rd_start = rd_state == tape_pkg::RD_IDLE && !console_reset
                    && ((rdr_sel && !rdr_no_tape && !ri) || ri_go || ri);
  assign frame_in = rd_state == tape_pkg::RD_WAIT && rdr_frame.valid;
  assign next_buf = {rd_buf[11:0], rdr_frame.data[5:0]};
  assign rd_complete = frame_in && (!rd_binary
                       || (rdr_frame.data[tape_pkg::HOLE8] && rd_cnt == tape_pkg::BIN_LAST));
  assign last_now = rd_last || rdr_frame.data[tape_pkg::HOLE7];

  always_ff @(posedge aclk) begin
    if (!aresetn || console_reset) begin
      rd_state <= tape_pkg::RD_IDLE;
      rd_binary <= 1'b0;
      rd_cnt <= 2'h0;
      rd_last <= 1'b0;
      rd_buf <= 18'h0_0000;
      rdr_advance <= 1'b0;
    end else begin
      rdr_advance <= 1'b0;
      case (rd_state)
        tape_pkg::RD_IDLE: begin
          if (rd_start) begin
            rd_state <= tape_pkg::RD_WAIT;
            rd_binary <= io_transfer_instruction.pulse[tape_pkg::P_BINARY] && rdr_sel || ri_go || ri;
            rd_cnt <= 2'h0;
            rd_last <= 1'b0;
            rd_buf <= 18'h0_0000;
            rdr_advance <= 1'b1;
          end
        end
        tape_pkg::RD_WAIT: begin
          if (frame_in && !rd_binary) begin
            rd_buf <= {10'h000, rdr_frame.data};
            rd_state <= tape_pkg::RD_IDLE;
          end else if (frame_in) begin
            // Frames without hole 8 are leader or trailer and do not count
            if (rdr_frame.data[tape_pkg::HOLE8]) begin
              rd_buf <= next_buf;
              rd_cnt <= rd_cnt + 2'h1;
              rd_last <= last_now;
            end
            if (rd_complete) begin
              rd_state <= tape_pkg::RD_IDLE;
            end else begin
              rdr_advance <= 1'b1;
            end
          end
        end
        default: rd_state <= tape_pkg::RD_IDLE;
      endcase
    end
  end

  // Set wins over a clear in the same cycle so a completed frame is never lost
  always_ff @(posedge aclk) begin
    if (!aresetn || console_reset) begin
      rdr_flag <= 1'b0;
      rdr_irq <= 1'b0;
    end else begin
      if (rd_complete || (rdr_sel && rdr_no_tape && !ri)) begin
        rdr_flag <= 1'b1;
        rdr_irq <= 1'b1;
      end else if (rdr_rd || rd_start) begin
        rdr_flag <= 1'b0;
        rdr_irq <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || console_reset) begin
      ri <= 1'b0;
      ri_pi_req <= 1'b0;
      ri_skip_req <= 1'b0;
      ri_word <= 18'h0_0000;
    end else begin
      ri_pi_req <= 1'b0;
      ri_skip_req <= 1'b0;
      if (ri_go) begin
        ri <= 1'b1;
      end else if (ri && rd_complete) begin
        ri_word <= next_buf;
        ri_pi_req <= 1'b1;
        if (last_now) begin
          ri_skip_req <= 1'b1;
          ri <= 1'b0;
        end
      end
    end
  end

  // ****************************************************************
  // Punch
  // ****************************************************************
  always_comb begin
    next_pun_buf = ac[7:0];
    if (io_transfer_instruction.pulse[tape_pkg::P_BINARY]) begin
      next_pun_buf[tape_pkg::HOLE8] = 1'b1;
      next_pun_buf[tape_pkg::HOLE7] = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pu_state <= tape_pkg::PU_IDLE;
      pun_buf <= 8'h00;
      pun_strobe <= 1'b0;
    end else begin
      pun_strobe <= 1'b0;
      case (pu_state)
        tape_pkg::PU_IDLE: begin
          if (pun_go) begin
            pun_buf <= next_pun_buf;
            pun_strobe <= 1'b1;
            pu_state <= tape_pkg::PU_BUSY;
          end else if (pun_clr) begin
            pun_buf <= 8'h00;
          end
        end
        tape_pkg::PU_BUSY: begin
          if (pun_done) begin
            pu_state <= tape_pkg::PU_IDLE;
          end
        end
        default: pu_state <= tape_pkg::PU_IDLE;
      endcase
    end
  end

  // Comes out of reset ready so a first skip test does not hang
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pun_flag <= 1'b1;
      pun_irq <= 1'b1;
    end else if (pu_state == tape_pkg::PU_BUSY && pun_done) begin
      pun_flag <= 1'b1;
      pun_irq <= 1'b1;
    end else if (pun_clr || pun_go) begin
      pun_flag <= 1'b0;
      pun_irq <= 1'b0;
    end
  end

  // ****************************************************************
  // Accumulator and skip result
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ac <= tape_pkg::AC_RESET;
    end else if (rdr_rd && io_transfer_instruction.pulse[tape_pkg::P_CLR_AC]) begin
      ac <= rd_buf;
    end else if (rdr_rd) begin
      ac <= ac | rd_buf;
    end else if (sts_cmd) begin
      ac <= tape_pkg::AC_RESET;
      ac[tape_pkg::AC_RDR_FLAG] <= rdr_flag;
      ac[tape_pkg::AC_RDR_NOTAPE] <= rdr_no_tape;
      ac[tape_pkg::AC_PUN_FLAG] <= pun_flag;
      ac[tape_pkg::AC_PUN_NOTAPE] <= pun_no_tape;
    end else if (wr_fire && awaddr_q == tape_pkg::ADDR_AC) begin
      ac <= 18'(merge({14'h0000, ac}, wdata_q, wstrb_q));
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      skip <= 1'b0;
    end else if (exec) begin
      skip <= (rdr_cmd && io_transfer_instruction.pulse[tape_pkg::P_SKIP] && rdr_flag)
              || (pun_cmd && io_transfer_instruction.pulse[tape_pkg::P_SKIP] && pun_flag);
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_char_load: assert property (frame_in && !rd_binary && !console_reset
    |=> rdr_flag && rd_buf[7:0] == $past(rdr_frame.data)) else $error("char frame lost");
  a_irq_flag: assert property (rd_complete && !console_reset |=> rdr_irq)
    else $error("reader request missing");
  a_rdr_skip: assert property (rdr_cmd && io_transfer_instruction.pulse[tape_pkg::P_SKIP]
    |=> skip == $past(rdr_flag)) else $error("reader skip wrong");
  a_rrb_load: assert property (rdr_rd && io_transfer_instruction.pulse[tape_pkg::P_CLR_AC] && !frame_in
    && !console_reset |=> ac == $past(rd_buf) && !rdr_flag) else $error("clearing read wrong");
  a_or_read: assert property (rdr_rd && !io_transfer_instruction.pulse[tape_pkg::P_CLR_AC]
    |=> ac == ($past(ac) | $past(rd_buf))) else $error("or read wrong");
  a_sel_clear: assert property (rd_start ##1 rd_state == tape_pkg::RD_WAIT
    |-> !rdr_flag) else $error("select left flag set");
  a_bin_skip: assert property (frame_in && rd_binary && !rdr_frame.data[tape_pkg::HOLE8]
    && !console_reset |=> rd_cnt == $past(rd_cnt) && !rdr_flag) else $error("hole 8 ignored");
  a_bin_word: assert property (rd_complete && rd_binary && !console_reset
    |=> rd_buf == $past(next_buf) && rdr_flag) else $error("binary word wrong");
  a_readin_req: assert property (ri && rd_complete && !console_reset
    |=> ri_pi_req && ri_word == $past(next_buf)) else $error("readin word missing");
  a_readin_end: assert property (ri && rd_complete && last_now && !console_reset
    |=> ri_skip_req && !ri ##1 !ri_skip_req) else $error("readin end wrong");
  a_readin_bin: assert property (ri_go && !console_reset |=> rd_binary)
    else $error("readin not binary");
  a_console: assert property (console_reset |=> rd_state == tape_pkg::RD_IDLE
    && !ri && !rdr_flag) else $error("console reset ignored");
  a_pun_start: assert property (pun_go |=> pun_strobe && !pun_flag
    && pun_buf[5:0] == $past(ac[5:0])) else $error("punch start wrong");
  a_pun_bin: assert property (pun_go && io_transfer_instruction.pulse[tape_pkg::P_BINARY]
    |=> pun_buf[tape_pkg::HOLE8] && !pun_buf[tape_pkg::HOLE7]) else $error("binary frame bad");
  a_no_tape: assert property (pun_no_tape && pun_cmd |=> !pun_strobe)
    else $error("punched without tape");
  a_pun_done: assert property (pu_state == tape_pkg::PU_BUSY && pun_done
    |=> pun_flag && pu_state == tape_pkg::PU_IDLE) else $error("punch flag not set");
  a_pun_clear: assert property (pun_clr && !pun_go && pu_state == tape_pkg::PU_IDLE
    |=> !pun_flag && pun_buf == 8'h00) else $error("punch clear failed");
  a_status: assert property (sts_cmd |=> ac[tape_pkg::AC_PUN_FLAG] == $past(pun_flag)
    && ac[tape_pkg::AC_RDR_FLAG] == $past(rdr_flag)) else $error("status bits wrong");

  c_char: cover property (frame_in && !rd_binary);
  c_word: cover property (rd_complete && rd_binary && !ri);
  c_readin: cover property (ri_skip_req);
  c_punch: cover property (pu_state == tape_pkg::PU_BUSY && pun_done);
endmodule

//--- bench/tape_mech.sv
// Model of the tape reader and punch mechanisms facing the controller
`timescale 1ns/1ps
module tape_mech (
  input wire logic aclk, // Clock
  input wire logic rdr_advance, // Advance request
  input wire logic [7:0] tape_byte, // Next frame on tape
  output tape_pkg::frame_t rdr_frame, // Sensed frame
  output logic frame_sent, // Frame consumed
  input wire logic pun_strobe, // Punch start
  input wire logic [7:0] pun_buf, // Frame to punch
  output logic pun_done, // Punch finished
  output logic [7:0] punched, // Last frame punched
  output int punch_count // Frames punched
);
  int rd_cnt = 0;
  int pu_cnt = 0;
  initial begin
    rdr_frame = '0;
    frame_sent = 1'b0;
    pun_done = 1'b0;
    punched = 8'h00;
    punch_count = 0;
  end
  // Data lines flip outside a frame so a late sample never matches by luck
  always @(posedge aclk) begin
    frame_sent <= 1'b0;
    rdr_frame.valid <= 1'b0;
    rdr_frame.data <= ~rdr_frame.data;
    if (rdr_advance) begin
      rd_cnt <= 3;
    end else if (rd_cnt == 1) begin
      rd_cnt <= 0;
      rdr_frame <= '{data: tape_byte, valid: 1'b1};
      frame_sent <= 1'b1;
    end else if (rd_cnt > 1) begin
      rd_cnt <= rd_cnt - 1;
    end
  end
  always @(posedge aclk) begin
    pun_done <= 1'b0;
    if (pun_strobe) begin
      pu_cnt <= 5;
      punched <= pun_buf;
      punch_count <= punch_count + 1;
    end else if (pu_cnt == 1) begin
      pu_cnt <= 0;
      pun_done <= 1'b1;
    end else if (pu_cnt > 1) begin
      pu_cnt <= pu_cnt - 1;
    end
  end
endmodule

//--- bench/tb_top.sv
// Self-checking bench for the tape controller
`timescale 1ns/1ps
module tb_top;
  logic aclk, aresetn, s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic s_arvalid, s_arready, s_rvalid, s_rready, console_reset, readin_key;
  logic rdr_no_tape, rdr_advance, rdr_irq, ri_pi_req, ri_skip_req, pun_no_tape;
  logic pun_done, pun_strobe, pun_irq, frame_sent;
  logic [3:0] s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata, rd;
  logic [1:0] s_bresp, s_rresp, rr;
  logic [17:0] ri_word;
  logic [7:0] pun_buf, punched, tape_byte;
  tape_pkg::frame_t rdr_frame;
  int punch_count, num_errors = 0, checks_done = 0, cycles = 0, frames = 0;
  logic [7:0] tape_q[$];
  logic [18:0] ri_q[$];
  paper_tape_ctrl u_dut (.aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(4'hF),
    .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
    .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
    .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
    .s_rready(s_rready), .console_reset(console_reset), .readin_key(readin_key),
    .rdr_frame(rdr_frame), .rdr_no_tape(rdr_no_tape), .rdr_advance(rdr_advance),
    .rdr_irq(rdr_irq), .ri_pi_req(ri_pi_req), .ri_skip_req(ri_skip_req),
    .ri_word(ri_word), .pun_no_tape(pun_no_tape), .pun_done(pun_done),
    .pun_strobe(pun_strobe), .pun_buf(pun_buf), .pun_irq(pun_irq));
  tape_mech u_mech (.aclk(aclk), .rdr_advance(rdr_advance), .tape_byte(tape_byte),
    .rdr_frame(rdr_frame), .frame_sent(frame_sent), .pun_strobe(pun_strobe),
    .pun_buf(pun_buf), .pun_done(pun_done), .punched(punched),
    .punch_count(punch_count));
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  // Each advance pulls the next frame under the read head, one frame per request
  always @(posedge aclk) begin
    if (rdr_advance && tape_q.size() > 0) tape_byte <= tape_q.pop_front();
    if (frame_sent) frames <= frames + 1;
    if (ri_pi_req) ri_q.push_back({ri_skip_req, ri_word});
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      test_done();
    end
  end
  // ****************************************************************
  // Bus and check tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_awvalid && s_awready) s_awvalid <= 1'b0;
      if (s_wvalid && s_wready) s_wvalid <= 1'b0;
      if (s_bvalid) begin
        s_bready <= 1'b0;
        break;
      end
    end
    @(posedge aclk);
  endtask
  task automatic rdb(input logic [3:0] a);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_arvalid && s_arready) s_arvalid <= 1'b0;
      if (s_rvalid) begin
        rd = s_rdata;
        rr = s_rresp;
        s_rready <= 1'b0;
        break;
      end
    end
    @(posedge aclk);
  endtask
  task automatic wait_flag(input bit punch);
    for (int n = 0; n < 300 && (punch ? pun_irq : rdr_irq) !== 1'b1; n++) @(posedge aclk);
    chk(punch ? pun_irq : rdr_irq, 1'b1);
  endtask
  task automatic pulse_in(input bit key);
    if (key) readin_key <= 1'b1;
    else console_reset <= 1'b1;
    @(posedge aclk);
    if (key) readin_key <= 1'b0;
    else console_reset <= 1'b0;
  endtask
  task automatic test_done();
    if (num_errors == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    {aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
    {console_reset, readin_key, rdr_no_tape, pun_no_tape} = '0;
    s_awaddr = 4'h0;
    s_araddr = 4'h0;
    s_wdata = 32'h0000_0000;
    tape_byte = 8'h00;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rdb(tape_pkg::ADDR_STATUS);
    chk(rd, 32'h0000_0004);
    tape_q.push_back(8'hA5);
    wr(tape_pkg::ADDR_IOT, 32'h0003_8044);
    wait_flag(1'b0);
    chk(rdr_irq, 1'b1);
    wr(tape_pkg::ADDR_IOT, 32'h0003_8041);
    rdb(tape_pkg::ADDR_STATUS);
    chk(rd, 32'h0000_0007);
    wr(tape_pkg::ADDR_AC, 32'h0000_0300);
    wr(tape_pkg::ADDR_IOT, 32'h0003_8042);
    rdb(tape_pkg::ADDR_AC);
    chk(rd, 32'h0000_03A5);
    chk(rdr_irq, 1'b0);
    wr(tape_pkg::ADDR_AC, 32'h0003_FFFF);
    wr(tape_pkg::ADDR_IOT, 32'h0003_804A);
    rdb(tape_pkg::ADDR_AC);
    chk(rd, 32'h0000_00A5);
    wr(tape_pkg::ADDR_IOT, 32'h0003_8041);
    rdb(tape_pkg::ADDR_STATUS);
    chk(rd, 32'h0000_0004);
    tape_q = '{8'h81, 8'h3F, 8'h82, 8'h83};
    wr(tape_pkg::ADDR_IOT, 32'h0003_8064);
    wait_flag(1'b0);
    rdb(tape_pkg::ADDR_WORD);
    chk(rd, 32'h0000_1083);
    chk(frames, 5);
    wr(tape_pkg::ADDR_IOT, 32'h0003_804A);
    rdb(tape_pkg::ADDR_AC);
    chk(rd, 32'h0000_1083);
    wr(tape_pkg::ADDR_IOT, 32'h0003_8041);
    rdb(tape_pkg::ADDR_STATUS);
    chk(rd, 32'h0000_0004);
    wr(tape_pkg::ADDR_AC, 32'h0000_00FF);
    wr(tape_pkg::ADDR_IOT, 32'h0003_80A4);
    @(posedge aclk);
    chk(pun_irq, 1'b0);
    wait_flag(1'b1);
    chk(punched, 8'hBF);
    wr(tape_pkg::ADDR_AC, 32'h0000_005A);
    wr(tape_pkg::ADDR_IOT, 32'h0003_8084);
    wait_flag(1'b1);
    chk(punched, 8'h5A);
    wr(tape_pkg::ADDR_IOT, 32'h0003_8081);
    rdb(tape_pkg::ADDR_STATUS);
    chk(rd, 32'h0000_0005);
    wr(tape_pkg::ADDR_IOT, 32'h0003_8082);
    chk({pun_irq, pun_buf}, 9'h000);
    rdr_no_tape <= 1'b1;
    pun_no_tape <= 1'b1;
    wr(tape_pkg::ADDR_IOT, 32'h0003_8044);
    chk(rdr_irq, 1'b1);
    wr(tape_pkg::ADDR_IOT, 32'h0003_80CC);
    rdb(tape_pkg::ADDR_AC);
    chk(rd, 32'h0001_0300);
    wr(tape_pkg::ADDR_IOT, 32'h0003_8084);
    repeat (20) @(posedge aclk);
    chk(punch_count, 2);
    rdr_no_tape <= 1'b0;
    pun_no_tape <= 1'b0;
    rdb(4'h2);
    chk(rr, tape_pkg::RESP_SLVERR);
    chk(rd, 32'h0000_0000);
    tape_q = '{8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'hC6};
    pulse_in(1'b0);
    pulse_in(1'b1);
    for (int n = 0; n < 400 && ri_q.size() < 2; n++) @(posedge aclk);
    chk(ri_q.size(), 2);
    chk(ri_q[0], 19'h0_1083);
    chk(ri_q[1], 19'h4_4146);
    test_done();
  end
endmodule
